// >>> shared/wbc_wake_bus_regs.vh
// Constants of the wake and bus control register bank.
// How it works
// - Codes 000-011: off, wake, receive, normal.
// - Codes 100-111 same; all but 100 add selective wake.
// - Selective wake bit changes only by host or soft reset.
// - Sleep entry, no error: normal becomes wake.
// - Receive-only: wake on Sleep, kept on Stop.
// - Wake capable or off stays on entry.
// - Fail-safe entry forces wake-source register values.
// - Bit 5 selects low or high threshold.
// - Threshold writable in Init, Normal; else ignored.
// - Ignored threshold write raises no error, interrupt.
// - Bits 7, 6 enable cyclic timer wakes.
// - Bit 2 disables watchdog in Stop mode.
// - Bit 7 chooses wake-only or all-status interrupt.
// - Measure bit disables wake pins 1, 2.
// - Bits 2..0 enable wake pins 3..1.
// - Reserved bits always read as zero.
// - Reset loads 07 external, zeros elsewhere.
// - Restart clears watchdog bit, keeps selective wake, sets mode bits.
`ifndef WBC_WAKE_BUS_REGS_VH
`define WBC_WAKE_BUS_REGS_VH
// ==========================================================
// Register addresses
`define WBC_ADDR_BUS_MODE   7'h04
`define WBC_ADDR_PEAK       7'h05
`define WBC_ADDR_INT_WAKE   7'h06
`define WBC_ADDR_EXT_WAKE   7'h07
// ==========================================================
// Reset values and writable masks
`define WBC_RST_BUS_MODE    8'h00
`define WBC_RST_PEAK        8'h00
`define WBC_RST_INT_WAKE    8'h00
`define WBC_RST_EXT_WAKE    8'h07
`define WBC_MASK_BUS_MODE   8'h07
`define WBC_MASK_PEAK       8'h20
`define WBC_MASK_INT_WAKE   8'hc4
`define WBC_MASK_EXT_WAKE   8'ha7
`define WBC_MASK_SEL_WAKE   8'h04
// ==========================================================
// Field positions
`define WBC_BIT_SEL_WAKE    2
`define WBC_BIT_PEAK        5
`define WBC_BIT_TIMER2      7
`define WBC_BIT_TIMER1      6
`define WBC_BIT_WD_STOP     2
`define WBC_BIT_INT_GLOBAL  7
`define WBC_BIT_MEASURE     5
`define WBC_BIT_PIN3        2
`define WBC_BIT_PIN2        1
`define WBC_BIT_PIN1        0
// ==========================================================
// Transceiver mode codes in the two low bits
`define WBC_MODE_OFF        2'h0
`define WBC_MODE_WAKE       2'h1
`define WBC_MODE_RXONLY     2'h2
`define WBC_MODE_NORMAL     2'h3
// ==========================================================
// Fail-safe and restart patterns
`define WBC_FS_BUS_LOW      8'h01
`define WBC_FS_EXT_KEEP     8'ha0
`define WBC_FS_EXT_SET      8'h07
`define WBC_RS_INT_KEEP     8'hc0
// ==========================================================
// Serial frame counts
`define WBC_FRAME_BITS      5'h10
`define WBC_HDR_BITS        5'h08
`define WBC_CNT_MAX         5'h1f
`define WBC_SYNC_RST        3'h2
`endif

// >>> core/wbc_pin_sync.v
// Two-flop synchroniser for the serial interface pins.
`timescale 1ns/10ps
`default_nettype none
`include "wbc_wake_bus_regs.vh"
module wbc_pin_sync (
	input  wire       clk,
	input  wire       sys_rst,
	input  wire [2:0] pinIn,
	output wire [2:0] pinSync
);
	reg [2:0] stage1_ff;
	reg [2:0] stage2_ff;
	// Idle levels of the pins, so no false edge follows reset.
	localparam [2:0] SYNC_RST = `WBC_SYNC_RST;
	genvar i;
	// Each pin passes two flops; only the second one is read.
	generate
		for (i = 0; i < 3; i = i + 1) begin : gSync
			always @(posedge clk or posedge sys_rst) begin
				if (sys_rst) begin
					stage1_ff[i] <= SYNC_RST[i];
					stage2_ff[i] <= SYNC_RST[i];
				end else begin
					stage1_ff[i] <= pinIn[i];
					stage2_ff[i] <= stage1_ff[i];
				end
			end
		end
	endgenerate
	assign pinSync = stage2_ff;
endmodule
`default_nettype wire

// >>> core/wbc_spi_shift.v
// Serial frame engine: shifts in 16-bit frames, shifts out read data.
`timescale 1ns/10ps
`default_nettype none
`include "wbc_wake_bus_regs.vh"
module wbc_spi_shift (
	input  wire        clk,
	input  wire        sys_rst,
	input  wire        sclkSync,
	input  wire        spiCsN,
	input  wire        mosiSync,
	input  wire [7:0]  readData,
	output wire [15:0] frameWord,
	output reg         frameDone_ff,
	output reg         misoOut_ff,
	output reg         misoOe_ff
);
	reg        sclkPrev_ff;
	reg        csnPrev_ff;
	reg [4:0]  bitCnt_ff;
	reg [15:0] shift_ff;
	reg [7:0]  tx_ff;
	wire       sclkRise;
	wire       sclkFall;
	wire       csnFall;
	wire       csnRise;

	// Edge detection on the synchronised pins.
	assign sclkRise = sclkSync & ~sclkPrev_ff;
	assign sclkFall = ~sclkSync & sclkPrev_ff;
	assign csnFall  = ~spiCsN & csnPrev_ff;
	assign csnRise  = spiCsN & ~csnPrev_ff;
	assign frameWord = shift_ff;

	// Frame counting, input shifting and output shifting.
	always @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			sclkPrev_ff  <= 1'b0;
			csnPrev_ff   <= 1'b1;
			bitCnt_ff    <= 5'h00;
			shift_ff     <= 16'h0000;
			tx_ff        <= 8'h00;
			frameDone_ff <= 1'b0;
			misoOut_ff   <= 1'b0;
			misoOe_ff    <= 1'b0;
		end else begin
			sclkPrev_ff  <= sclkSync;
			csnPrev_ff   <= spiCsN;
			misoOe_ff    <= ~spiCsN;
			// Only a frame of exactly 16 clocks commits.
			frameDone_ff <= csnRise & (bitCnt_ff == `WBC_FRAME_BITS);
			if (csnFall) begin
				bitCnt_ff  <= 5'h00;
				misoOut_ff <= 1'b0;
			end else if (~spiCsN & sclkRise) begin
				shift_ff <= {shift_ff[14:0], mosiSync};
				if (bitCnt_ff != `WBC_CNT_MAX)
					bitCnt_ff <= bitCnt_ff + 5'h01;
			end else if (~spiCsN & sclkFall) begin
				if (bitCnt_ff == `WBC_HDR_BITS) begin
					misoOut_ff <= readData[7];
					tx_ff      <= {readData[6:0], 1'b0};
				end else begin
					misoOut_ff <= tx_ff[7];
					tx_ff      <= {tx_ff[6:0], 1'b0};
				end
			end
		end
	end
endmodule
`default_nettype wire

// >>> core/wbc_wake_bus_ctrl_regs.v
// Wake and bus control register bank with its serial access port.
`timescale 1ns/10ps
`default_nettype none
`include "wbc_wake_bus_regs.vh"
module wbc_wake_bus_ctrl_regs (
	input  wire       clk,
	input  wire       sys_rst,
	input  wire       spiSclk,
	input  wire       spiCsN,
	input  wire       spiMosi,
	output wire       spiMisoOut,
	output wire       spiMisoOe,
	input  wire       softReset,
	input  wire       modeInit,
	input  wire       modeNormal,
	input  wire       modeStop,
	input  wire       sleepEntry,
	input  wire       stopEntry,
	input  wire       failSafeEntry,
	input  wire       restartEntry,
	input  wire [1:0] restartBusMode,
	input  wire       systemErrorFlag,
	input  wire       wakeEvent,
	input  wire       statusEvent,
	output reg  [1:0] busMode_ff,
	output reg        selectiveWake_ff,
	output reg        supplyPeakThresholdSel_ff,
	output reg        cyclicTimer2WakeEnable_ff,
	output reg        cyclicTimer1WakeEnable_ff,
	output reg        watchdogStopDisableB1_ff,
	output reg        intGlobalSel_ff,
	output reg        wakePinMeasureActive_ff,
	output reg  [2:0] wakePinEnable_ff,
	output reg        intRequest_ff
);
	// ==========================================================
	// Declarations
	reg  [7:0]  busReg_ff;
	reg  [7:0]  peakReg_ff;
	reg  [7:0]  intWakeReg_ff;
	reg  [7:0]  extWakeReg_ff;
	reg  [7:0]  nxt_busReg;
	reg  [7:0]  nxt_peakReg;
	reg  [7:0]  nxt_intWakeReg;
	reg  [7:0]  nxt_extWakeReg;
	reg  [7:0]  readData;
	wire [2:0]  pinSync;
	wire [15:0] frameWord;
	wire        frameDone;
	wire        hostWrite;
	wire [6:0]  wrAddr;
	wire [7:0]  wrData;
	wire [6:0]  rdAddr;
	wire        peakWritable;

	// ==========================================================
	// Pin synchroniser and frame engine
	wbc_pin_sync uSync (
		.clk     (clk),
		.sys_rst (sys_rst),
		.pinIn   ({spiMosi, spiCsN, spiSclk}),
		.pinSync (pinSync)
	);

	wbc_spi_shift uShift (
		.clk          (clk),
		.sys_rst      (sys_rst),
		.sclkSync     (pinSync[0]),
		.spiCsN       (pinSync[1]),
		.mosiSync     (pinSync[2]),
		.readData     (readData),
		.frameWord    (frameWord),
		.frameDone_ff (frameDone),
		.misoOut_ff   (spiMisoOut),
		.misoOe_ff    (spiMisoOe)
	);

	// Frame layout: write flag, 7-bit address, 8 data bits.
	assign hostWrite = frameDone & frameWord[15];
	assign wrAddr    = frameWord[14:8];
	assign wrData    = frameWord[7:0];
	// After the header the address sits in the low seven bits.
	assign rdAddr    = frameWord[6:0];
	assign peakWritable = (modeInit | modeNormal) & ~modeStop;

	// ==========================================================
	// Read decode
	// Registers are kept masked, so reserved bits read zero.
	always @* begin
		if (rdAddr == `WBC_ADDR_BUS_MODE) begin
			readData = busReg_ff & `WBC_MASK_BUS_MODE;
		end else if (rdAddr == `WBC_ADDR_PEAK) begin
			readData = peakReg_ff & `WBC_MASK_PEAK;
		end else if (rdAddr == `WBC_ADDR_INT_WAKE) begin
			readData = intWakeReg_ff & `WBC_MASK_INT_WAKE;
		end else if (rdAddr == `WBC_ADDR_EXT_WAKE) begin
			readData = extWakeReg_ff & `WBC_MASK_EXT_WAKE;
		end else begin
			readData = 8'h00;
		end
	end

	// ==========================================================
	// Next register values
	// Priority: soft reset, fail-safe, restart, mode entry, host.
	always @* begin
		nxt_busReg     = busReg_ff;
		nxt_peakReg    = peakReg_ff;
		nxt_intWakeReg = intWakeReg_ff;
		nxt_extWakeReg = extWakeReg_ff;
		if (softReset) begin
			nxt_busReg     = `WBC_RST_BUS_MODE;
			nxt_peakReg    = `WBC_RST_PEAK;
			nxt_intWakeReg = `WBC_RST_INT_WAKE;
			nxt_extWakeReg = `WBC_RST_EXT_WAKE;
		end else if (failSafeEntry) begin
			// Wake sources are forced so the device can wake again.
			// The selective wake bit is kept as the host left it.
			nxt_busReg = (busReg_ff & `WBC_MASK_SEL_WAKE) |
				`WBC_FS_BUS_LOW;
			nxt_extWakeReg = (extWakeReg_ff & `WBC_FS_EXT_KEEP) |
				`WBC_FS_EXT_SET;
		end else if (restartEntry) begin
			// Selective wake and timer bits kept, watchdog bit clears, mode bits follow the restart cause.
			nxt_busReg = (busReg_ff & `WBC_MASK_SEL_WAKE) |
				{6'h00, restartBusMode};
			nxt_intWakeReg = intWakeReg_ff & `WBC_RS_INT_KEEP;
		end else if (sleepEntry) begin
			// Normal goes to wake capable only without system error.
			if (busReg_ff[1:0] == `WBC_MODE_NORMAL) begin
				if (~systemErrorFlag)
					nxt_busReg[1:0] = `WBC_MODE_WAKE;
			end else if (busReg_ff[1:0] == `WBC_MODE_RXONLY) begin
				nxt_busReg[1:0] = `WBC_MODE_WAKE;
			end
			// Wake capable and off codes are left as they are.
		end else if (stopEntry) begin
			// Stop entry keeps every code, receive-only included.
			nxt_busReg = busReg_ff;
		end else if (hostWrite) begin
			if (wrAddr == `WBC_ADDR_BUS_MODE) begin
				// All three mode bits, selective wake included.
				nxt_busReg = wrData & `WBC_MASK_BUS_MODE;
			end else if (wrAddr == `WBC_ADDR_PEAK) begin
				// Outside Init and Normal the write is dropped quietly.
				if (peakWritable)
					nxt_peakReg = wrData & `WBC_MASK_PEAK;
			end else if (wrAddr == `WBC_ADDR_INT_WAKE) begin
				nxt_intWakeReg = wrData & `WBC_MASK_INT_WAKE;
			end else if (wrAddr == `WBC_ADDR_EXT_WAKE) begin
				nxt_extWakeReg = wrData & `WBC_MASK_EXT_WAKE;
			end
		end
	end

	// ==========================================================
	// Register storage
	always @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			busReg_ff     <= `WBC_RST_BUS_MODE;
			peakReg_ff    <= `WBC_RST_PEAK;
			intWakeReg_ff <= `WBC_RST_INT_WAKE;
			extWakeReg_ff <= `WBC_RST_EXT_WAKE;
		end else begin
			busReg_ff     <= nxt_busReg & `WBC_MASK_BUS_MODE;
			peakReg_ff    <= nxt_peakReg & `WBC_MASK_PEAK;
			intWakeReg_ff <= nxt_intWakeReg & `WBC_MASK_INT_WAKE;
			extWakeReg_ff <= nxt_extWakeReg & `WBC_MASK_EXT_WAKE;
		end
	end

	// ==========================================================
	// Control outputs
	// Outputs follow the stored values, modeNormal and the events one cycle later.
	always @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			busMode_ff                <= `WBC_MODE_OFF;
			selectiveWake_ff          <= 1'b0;
			supplyPeakThresholdSel_ff <= 1'b0;
			cyclicTimer2WakeEnable_ff <= 1'b0;
			cyclicTimer1WakeEnable_ff <= 1'b0;
			watchdogStopDisableB1_ff  <= 1'b0;
			intGlobalSel_ff           <= 1'b0;
			wakePinMeasureActive_ff   <= 1'b0;
			wakePinEnable_ff          <= 3'h0;
			intRequest_ff             <= 1'b0;
		end else begin
			// Low two bits select the transceiver mode.
			busMode_ff       <= busReg_ff[1:0];
			// Top bit adds selective wake except on the off code.
			selectiveWake_ff <= busReg_ff[`WBC_BIT_SEL_WAKE] &
				(busReg_ff[1:0] != `WBC_MODE_OFF);
			supplyPeakThresholdSel_ff <= peakReg_ff[`WBC_BIT_PEAK];
			cyclicTimer2WakeEnable_ff <=
				intWakeReg_ff[`WBC_BIT_TIMER2];
			cyclicTimer1WakeEnable_ff <=
				intWakeReg_ff[`WBC_BIT_TIMER1];
			watchdogStopDisableB1_ff <=
				intWakeReg_ff[`WBC_BIT_WD_STOP];
			intGlobalSel_ff <= extWakeReg_ff[`WBC_BIT_INT_GLOBAL];
			// Measurement runs in Normal mode only.
			wakePinMeasureActive_ff <= modeNormal &
				extWakeReg_ff[`WBC_BIT_MEASURE];
			// Pins 1 and 2 are ignored while measurement is chosen.
			wakePinEnable_ff[2] <= extWakeReg_ff[`WBC_BIT_PIN3];
			wakePinEnable_ff[1] <= extWakeReg_ff[`WBC_BIT_PIN2] &
				~extWakeReg_ff[`WBC_BIT_MEASURE];
			wakePinEnable_ff[0] <= extWakeReg_ff[`WBC_BIT_PIN1] &
				~extWakeReg_ff[`WBC_BIT_MEASURE];
			// Wake events always interrupt; status only if global.
			intRequest_ff <= wakeEvent | (statusEvent &
				extWakeReg_ff[`WBC_BIT_INT_GLOBAL]);
		end
	end
endmodule
`default_nettype wire

// >>> testbench/wbc_regs_chk.sv
// Assertion checker bound to the wake and bus control register bank.
`timescale 1ns/10ps
`default_nettype none
module wbc_regs_chk (
	input wire logic       clk,
	input wire logic       sys_rst,
	input wire logic       softReset,
	input wire logic       modeStop,
	input wire logic       sleepEntry,
	input wire logic       stopEntry,
	input wire logic       failSafeEntry,
	input wire logic       systemErrorFlag,
	input wire logic       wakeEvent,
	input wire logic       statusEvent,
	input wire logic [1:0] busMode_ff,
	input wire logic       selectiveWake_ff,
	input wire logic       supplyPeakThresholdSel_ff,
	input wire logic       intGlobalSel_ff,
	input wire logic       wakePinMeasureActive_ff,
	input wire logic [2:0] wakePinEnable_ff,
	input wire logic       intRequest_ff
);
	// ==========================================================
	// Mode changes: two clocks from pulse to output.
	default clocking cb @(posedge clk); endclocking
	default disable iff (sys_rst);
	property p_sleep_norm;
		sleepEntry && !systemErrorFlag && busMode_ff == 2'h3 |->
			##2 busMode_ff == 2'h1;
	endproperty
	a_sleep_norm: assert property (p_sleep_norm)
		else $error("normal code not turned to wake on sleep");
	property p_sel_keep;
		(sleepEntry || stopEntry) && selectiveWake_ff |-> ##2 selectiveWake_ff;
	endproperty
	a_sel_keep: assert property (p_sel_keep)
		else $error("selective wake lost on mode entry");
	property p_rx_sleep;
		sleepEntry && busMode_ff == 2'h2 |-> ##2 busMode_ff == 2'h1;
	endproperty
	a_rx_sleep: assert property (p_rx_sleep)
		else $error("receive only not turned to wake on sleep");
	property p_rx_stop;
		stopEntry && busMode_ff == 2'h2 |-> ##2 busMode_ff == 2'h2;
	endproperty
	a_rx_stop: assert property (p_rx_stop)
		else $error("receive only changed on stop");
	property p_low_keep;
		(sleepEntry || stopEntry) && busMode_ff < 2'h2 |->
			##2 busMode_ff == $past(busMode_ff, 2);
	endproperty
	a_low_keep: assert property (p_low_keep)
		else $error("wake or off code changed on mode entry");
	property p_fs;
		failSafeEntry |-> ##2 busMode_ff == 2'h1 && wakePinEnable_ff[2];
	endproperty
	a_fs: assert property (p_fs)
		else $error("fail-safe wake values not forced");
	// ==========================================================
	// Output relations: measurement pins, stop-mode threshold, interrupts, reset release.
	property p_meas;
		wakePinMeasureActive_ff |-> wakePinEnable_ff[1:0] == 2'h0;
	endproperty
	a_meas: assert property (p_meas)
		else $error("pins 1 and 2 enabled while measuring");
	property p_peak;
		modeStop && $past(modeStop) && $past(modeStop, 2) &&
			!$past(softReset) && !$past(softReset, 2) |->
			$stable(supplyPeakThresholdSel_ff);
	endproperty
	a_peak: assert property (p_peak)
		else $error("peak threshold changed in stop mode");
	property p_int_wake;
		$past(wakeEvent) |-> intRequest_ff;
	endproperty
	a_int_wake: assert property (p_int_wake)
		else $error("wake event gave no interrupt");
	property p_int_quiet;
		!$past(wakeEvent) && !$past(statusEvent) |-> !intRequest_ff;
	endproperty
	a_int_quiet: assert property (p_int_quiet)
		else $error("interrupt without any event");
	property p_int_all;
		$past(statusEvent) && intGlobalSel_ff && $past(intGlobalSel_ff)
			|-> intRequest_ff;
	endproperty
	a_int_all: assert property (p_int_all)
		else $error("status event gave no interrupt");
	property p_rst;
		$past(sys_rst) && !sys_rst |->
			##1 wakePinEnable_ff == 3'h7 && busMode_ff == 2'h0;
	endproperty
	a_rst: assert property (p_rst)
		else $error("reset values wrong after release");
endmodule
bind wbc_wake_bus_ctrl_regs wbc_regs_chk wbc_regs_chk_inst (.*);
`default_nettype wire

// >>> testbench/wbc_host_model.sv
// Host controller model that sends 16-bit serial frames.
`timescale 1ns/10ps
`default_nettype none
module wbc_host_model (
	input  wire logic clk,
	output var  logic spiSclk,
	output var  logic spiCsN,
	output var  logic spiMosi,
	input  wire logic spiMisoOut
);
	// ==========================================================
	// Half period of the serial clock, above the three-clock minimum.
	localparam int HALF = 5;
	initial begin
		spiSclk = 1'b0;
		spiCsN  = 1'b1;
		spiMosi = 1'b0;
	end
	// One frame: write flag, address and data; returns the second byte.
	task automatic xfer(input logic wr, input logic [6:0] addr,
		input logic [7:0] din, output logic [7:0] dout);
		logic [15:0] word;
		word = {wr, addr, din};
		dout = 8'h00;
		spiCsN = 1'b0;
		for (int i = 15; i >= 0; i--) begin
			spiMosi = word[i];
			repeat (HALF) @(negedge clk);
			if (i < 8)
				dout[i] = spiMisoOut;
			spiSclk = 1'b1;
			repeat (HALF) @(negedge clk);
			spiSclk = 1'b0;
		end
		repeat (HALF) @(negedge clk);
		spiCsN  = 1'b1;
		// Released data line shows the inverse, never the last bit.
		spiMosi = ~spiMosi;
		repeat (12) @(negedge clk);
	endtask
endmodule
`default_nettype wire

// >>> testbench/tb_top.sv
// Self-checking bench for the wake and bus control register bank.
`timescale 1ns/10ps
`default_nettype none
module tb_top;
	logic       clk = 1'b0, sys_rst = 1'b1;
	logic       spiSclk, spiCsN, spiMosi, spiMisoOut, spiMisoOe;
	logic       softReset, modeInit, modeNormal, modeStop;
	logic       sleepEntry, stopEntry, failSafeEntry, restartEntry;
	logic [1:0] restartBusMode, busMode_ff;
	logic       systemErrorFlag, wakeEvent, statusEvent, intRequest_ff;
	logic       selectiveWake_ff, supplyPeakThresholdSel_ff;
	logic       cyclicTimer2WakeEnable_ff, cyclicTimer1WakeEnable_ff;
	logic       watchdogStopDisableB1_ff, intGlobalSel_ff;
	logic       wakePinMeasureActive_ff;
	logic [2:0] wakePinEnable_ff;
	logic [7:0] rd;
	int         bad_count = 0, checked = 0;
	wbc_wake_bus_ctrl_regs wbc_wake_bus_ctrl_regs_inst (.*);
	wbc_host_model wbc_host_model_inst (.*);
	// ==========================================================
	// Clock, shared checks and bus helpers.
	always #50 clk = ~clk;
	task automatic stop_test;
		$display("checked %0d bad_count %0d", checked, bad_count);
		if (bad_count == 0 && checked > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		checked++;
		if (got !== exp) begin
			bad_count++;
			$display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic wr(input logic [6:0] a, input logic [7:0] d);
		wbc_host_model_inst.xfer(1'b1, a, d, rd);
	endtask
	task automatic rdchk(input logic [6:0] a, input logic [7:0] e);
		wbc_host_model_inst.xfer(1'b0, a, 8'h00, rd);
		chk(rd, e);
	endtask
	// One-cycle event pulse, then time for outputs to settle.
	task automatic pulse(input logic [6:0] m);
		{softReset, statusEvent, wakeEvent, failSafeEntry, restartEntry,
			stopEntry, sleepEntry} = m;
		@(negedge clk);
		{softReset, statusEvent, wakeEvent, failSafeEntry, restartEntry,
			stopEntry, sleepEntry} = 7'h00;
		repeat (3) @(negedge clk);
	endtask
	// ==========================================================
	// Scenarios.
	task automatic t_defaults;
		rdchk(7'h04, 8'h00);
		rdchk(7'h05, 8'h00);
		rdchk(7'h06, 8'h00);
		rdchk(7'h07, 8'h07);
		rdchk(7'h1c, 8'h00);
		chk({5'h00, wakePinEnable_ff}, 8'h07);
		chk({7'h00, spiMisoOe}, 8'h00);
	endtask
	task automatic t_masks;
		logic [7:0] mk [4];
		mk = '{8'h07, 8'h20, 8'hc4, 8'ha7};
		for (int i = 0; i < 4; i++) begin
			wr(7'(i + 4), 8'hff);
			rdchk(7'(i + 4), mk[i]);
		end
		chk({cyclicTimer2WakeEnable_ff, cyclicTimer1WakeEnable_ff,
			supplyPeakThresholdSel_ff, watchdogStopDisableB1_ff,
			intGlobalSel_ff, wakePinMeasureActive_ff,
			wakePinEnable_ff[2:1]}, 8'hfe);
		wr(7'h07, 8'h03);
		chk({intGlobalSel_ff, 4'h0, wakePinEnable_ff}, 8'h03);
	endtask
	task automatic t_modes;
		for (int c = 0; c < 8; c++) begin
			wr(7'h04, 8'(c));
			chk({5'h00, selectiveWake_ff, busMode_ff},
				(c == 4) ? 8'h00 : 8'(c));
		end
	endtask
	task automatic t_sleep;
		wr(7'h04, 8'h07);
		pulse(7'h01);
		rdchk(7'h04, 8'h05);
		wr(7'h04, 8'h02);
		pulse(7'h02);
		rdchk(7'h04, 8'h02);
		pulse(7'h01);
		rdchk(7'h04, 8'h01);
		pulse(7'h02);
		rdchk(7'h04, 8'h01);
		wr(7'h04, 8'h03);
		systemErrorFlag = 1'b1;
		pulse(7'h01);
		rdchk(7'h04, 8'h03);
		systemErrorFlag = 1'b0;
		wr(7'h04, 8'h04);
		pulse(7'h01);
		rdchk(7'h04, 8'h04);
	endtask
	task automatic t_peak;
		wr(7'h05, 8'h20);
		{modeInit, modeNormal, modeStop} = 3'b001;
		wr(7'h05, 8'h00);
		rdchk(7'h05, 8'h20);
		chk({7'h00, intRequest_ff}, 8'h00);
		{modeInit, modeNormal, modeStop} = 3'b100;
		wr(7'h05, 8'h00);
		rdchk(7'h05, 8'h00);
		chk({7'h00, supplyPeakThresholdSel_ff}, 8'h00);
		{modeInit, modeNormal, modeStop} = 3'b010;
	endtask
	// Interrupt request stands one cycle after the event it follows.
	task automatic t_irq;
		wr(7'h07, 8'h07);
		statusEvent = 1'b1;
		@(negedge clk);
		chk({7'h00, intRequest_ff}, 8'h00);
		statusEvent = 1'b0;
		wakeEvent = 1'b1;
		@(negedge clk);
		chk({7'h00, intRequest_ff}, 8'h01);
		wakeEvent = 1'b0;
		wr(7'h07, 8'h87);
		statusEvent = 1'b1;
		@(negedge clk);
		chk({7'h00, intRequest_ff}, 8'h01);
		statusEvent = 1'b0;
		@(negedge clk);
		chk({7'h00, intRequest_ff}, 8'h00);
	endtask
	task automatic t_fail_restart;
		wr(7'h04, 8'h07);
		wr(7'h07, 8'ha0);
		pulse(7'h08);
		rdchk(7'h04, 8'h05);
		rdchk(7'h07, 8'ha7);
		pulse(7'h20);
		pulse(7'h10);
		wr(7'h06, 8'hc4);
		restartBusMode = 2'h2;
		pulse(7'h04);
		rdchk(7'h04, 8'h06);
		rdchk(7'h06, 8'hc0);
		pulse(7'h40);
		t_defaults();
	endtask
	// ==========================================================
	// Main sequence and hang guard.
	initial begin
		{modeInit, modeNormal, modeStop} = 3'b010;
		{softReset, statusEvent, wakeEvent, failSafeEntry, restartEntry,
			stopEntry, sleepEntry} = 7'h00;
		restartBusMode  = 2'h0;
		systemErrorFlag = 1'b0;
		repeat (10) @(negedge clk);
		sys_rst = 1'b0;
		repeat (4) @(negedge clk);
		t_defaults();
		t_masks();
		t_modes();
		t_sleep();
		t_peak();
		t_irq();
		t_fail_restart();
		stop_test();
	end
	initial begin
		repeat (90000) @(posedge clk);
		bad_count++;
		stop_test();
	end
endmodule
`default_nettype wire
